// >>> include/bipf_pkg.sv
package bipf_pkg;

  // Port geometry
  localparam int unsigned BIPF_NPORTS = 11;
  localparam int unsigned BIPF_NIB    = 4;

  // Register byte offsets
  localparam logic [7:0] BIPF_OFS_CTRL   = 8'h00;
  localparam logic [7:0] BIPF_OFS_SENSE  = 8'h04;
  localparam logic [7:0] BIPF_OFS_FMT_A  = 8'h08;
  localparam logic [7:0] BIPF_OFS_FMT_B  = 8'h0C;
  localparam logic [7:0] BIPF_OFS_OUT_LO = 8'h10;
  localparam logic [7:0] BIPF_OFS_OUT_HI = 8'h14;
  localparam logic [7:0] BIPF_OFS_IN_ALO = 8'h18;
  localparam logic [7:0] BIPF_OFS_IN_AHI = 8'h1C;
  localparam logic [7:0] BIPF_OFS_IN_BLO = 8'h20;
  localparam logic [7:0] BIPF_OFS_IN_BHI = 8'h24;
  localparam logic [7:0] BIPF_OFS_STATUS = 8'h28;

  // Control register bits
  localparam int unsigned BIPF_CTRL_START_A = 0;
  localparam int unsigned BIPF_CTRL_START_B = 1;
  localparam int unsigned BIPF_CTRL_DIR_A   = 2;
  localparam int unsigned BIPF_CTRL_DIR_B   = 3;
  localparam int unsigned BIPF_CTRL_LOADDEF = 4;
  localparam int unsigned BIPF_CTRL_DUAL    = 5;

  // Sense register bits
  localparam int unsigned BIPF_SNS_HS    = 0;
  localparam int unsigned BIPF_SNS_DATA  = 1;
  localparam int unsigned BIPF_SNS_FUNC  = 2;
  localparam int unsigned BIPF_SNS_SIGN  = 3;
  localparam int unsigned BIPF_SNS_TRAIL = 4;
  localparam logic [4:0]  BIPF_SENSE_RST = 5'h00;

  // Format register field positions
  localparam int unsigned BIPF_FMT_MANT_LSB = 0;
  localparam int unsigned BIPF_FMT_EXP_LSB  = 4;
  localparam int unsigned BIPF_FMT_FUNC_LSB = 8;
  localparam int unsigned BIPF_FMT_DP_LSB   = 12;

  // Out/in high word field positions
  localparam int unsigned BIPF_HI_SIGN_LSB = 16;

  // Status register bits
  localparam int unsigned BIPF_ST_BUSY_LSB = 0;
  localparam int unsigned BIPF_ST_DONE_LSB = 2;
  localparam int unsigned BIPF_ST_FLAG_LSB = 4;
  localparam int unsigned BIPF_ST_SWITCH   = 6;

  // Digit count limits
  localparam logic [3:0] BIPF_MAX_MANT  = 4'hB;
  localparam logic [1:0] BIPF_MAX_EXP   = 2'h3;
  localparam logic [3:0] BIPF_MAX_FUNC  = 4'hB;
  localparam logic [4:0] BIPF_MAX_TOTAL = 5'h0B;

  // Single channel default format (channel A only)
  localparam logic [3:0] BIPF_STD_MANT = 4'h8;
  localparam logic [1:0] BIPF_STD_EXP  = 2'h1;
  localparam logic [3:0] BIPF_STD_FUNC = 4'h1;
  // Dual channel default format (same for A and B)
  localparam logic [3:0] BIPF_DUAL_MANT = 4'h4;
  localparam logic [1:0] BIPF_DUAL_EXP  = 2'h0;
  localparam logic [3:0] BIPF_DUAL_FUNC = 4'h1;

  // Per-channel handshake states
  typedef enum logic [1:0] {
    BIPF_IDLE = 2'b00,
    BIPF_TRIG = 2'b01,
    BIPF_BUSY = 2'b10
  } bipf_chan_st_t;

endpackage

// >>> design/bipf_formatter.sv
// Added by the designer: the address map and register access over APB.
`timescale 1ns/1ns

// Behaviour
// - Positive sense: codes 0-9 digits, 10-15 symbols
// - Negative sense uses complemented nibble
// - Eleven bidirectional four-bit digit ports
// - Separate sign port: two signs per channel
// - Direction and trigger outputs per channel
// - Digit counts: mantissa 0-11, exponent 0-3, function 0-11
// - Total digits over eleven is rejected
// - Decimal point position held per channel
// - Per-group logic sense, leading/trailing edge handshake
// - Default format from switch or program
// - Switch zero: A gets 8 mantissa, exponent, function
// - Switch one: A and B get 4 mantissa, function
// - Floating-high port reads question mark or zero
// - Transfer starts by asserting the trigger true
// - Direction true means output, false means input
module bipf_formatter
  import bipf_pkg::*;
(
  // APB slave
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Reset-default strap
  input  wire logic        format_select_switch,
  // Digit ports
  input  wire logic [43:0] port_in,
  output logic      [43:0] port_out,
  output logic      [10:0] port_oe_n,
  // Sign port
  input  wire logic [3:0]  sign_port_in,
  output logic      [3:0]  sign_port_out,
  output logic      [3:0]  sign_port_oe_n,
  // Handshake lines
  output logic             direction_a,
  output logic             direction_b,
  output logic             trigger_a,
  output logic             trigger_b,
  input  wire logic        ready_flag_a,
  input  wire logic        ready_flag_b
);

  typedef struct packed {
    logic                 init;
    logic                 fmt_sw;
    logic [4:0]           sense;
    logic [1:0]           dir;
    logic [1:0][3:0]      mant;
    logic [1:0][1:0]      expn;
    logic [1:0][3:0]      func;
    logic [1:0][3:0]      dp;
    bipf_chan_st_t [1:0]  st;
    logic [1:0]           flag_prev;
    logic [1:0]           done;
    logic [43:0]          out_chars;
    logic [3:0]           out_signs;
    logic [1:0][43:0]     cap;
    logic [1:0][1:0]      cap_sign;
    logic [43:0]          port_out;
    logic [10:0]          port_oe_n;
    logic [3:0]           sign_out;
    logic [3:0]           sign_oe_n;
    logic [1:0]           trig_pin;
    logic [1:0]           dir_pin;
    logic [31:0]          prdata;
    logic                 pslverr;
  } bipf_state_t;

  localparam bipf_state_t BIPF_STATE_RST = '{
    sense: BIPF_SENSE_RST, port_oe_n: '1, sign_oe_n: '1, st: '{BIPF_IDLE, BIPF_IDLE},
    default: '0};

  bipf_state_t s_q;
  bipf_state_t s_d;

  // Same complement serves both directions, so one function codes and decodes
  function automatic logic [3:0] bipf_code(input logic [3:0] v, input logic neg);
    return neg ? ~v : v;
  endfunction

  function automatic logic [4:0] bipf_total(input logic [3:0] m, input logic [1:0] e,
                                            input logic [3:0] f);
    return 5'(m) + 5'(e) + 5'(f);
  endfunction

  // Field checks for a format write against the other channel's usage
  function automatic logic bipf_fmt_ok(input logic [31:0] w, input logic [4:0] other);
    logic [3:0] m;
    logic [1:0] e;
    logic [3:0] f;
    logic [3:0] p;
    m = w[BIPF_FMT_MANT_LSB +: 4];
    e = w[BIPF_FMT_EXP_LSB +: 2];
    f = w[BIPF_FMT_FUNC_LSB +: 4];
    p = w[BIPF_FMT_DP_LSB +: 4];
    return (m <= BIPF_MAX_MANT) && (e <= BIPF_MAX_EXP) && (f <= BIPF_MAX_FUNC)
        // Six bits so two full channels cannot wrap back under the limit
        && (6'(bipf_total(m, e, f)) + 6'(other) <= 6'(BIPF_MAX_TOTAL))
        && ((m == 4'h0) ? (p == 4'h0) : (p < m));
  endfunction

  logic [4:0]  tot_a;
  logic [4:0]  tot_b;
  logic [1:0]  flag_t;
  logic        setup;
  logic        wr_acc;
  logic        any_busy;

  assign tot_a    = bipf_total(s_q.mant[0], s_q.expn[0], s_q.func[0]);
  assign tot_b    = bipf_total(s_q.mant[1], s_q.expn[1], s_q.func[1]);
  assign flag_t   = {ready_flag_b, ready_flag_a} ^ {2{s_q.sense[BIPF_SNS_HS]}};
  assign setup    = psel & ~penable;
  assign wr_acc   = psel & penable & pwrite & ~s_q.pslverr;
  assign any_busy = (s_q.st[0] != BIPF_IDLE) | (s_q.st[1] != BIPF_IDLE);

  // Next-state logic for the whole block
  always_comb begin
    logic       load_def;
    logic       def_dual;
    logic [4:0] base;
    logic [4:0] ta;
    logic [4:0] tb;
    logic [4:0] off;
    logic [4:0] mx;
    logic       own_a;
    logic       own_b;
    logic       neg;
    logic       rise;
    logic       fall;
    logic       smp;
    logic [1:0] done_set;
    logic [1:0] done_clr;
    logic [1:0] start;
    int         p;
    load_def = 1'b0;
    def_dual = 1'b0;
    base     = '0;
    ta       = '0;
    tb       = '0;
    off      = '0;
    mx       = '0;
    own_a    = 1'b0;
    own_b    = 1'b0;
    neg      = 1'b0;
    rise     = 1'b0;
    fall     = 1'b0;
    smp      = 1'b0;
    done_set = '0;
    done_clr = '0;
    start    = '0;
    p        = 0;
    s_d      = s_q;

    // Strap is caught on the first clock after reset, never in the reset itself
    if (!s_q.init) begin
      s_d.init   = 1'b1;
      s_d.fmt_sw = format_select_switch;
      load_def   = 1'b1;
      def_dual   = format_select_switch;
    end

    // Read data and error are fixed in the setup phase so they come from flops
    if (setup) begin
      s_d.pslverr = 1'b0;
      s_d.prdata  = '0;
      unique case (paddr)
        BIPF_OFS_CTRL: begin
          s_d.prdata[BIPF_CTRL_DIR_A] = s_q.dir[0];
          s_d.prdata[BIPF_CTRL_DIR_B] = s_q.dir[1];
        end
        BIPF_OFS_SENSE: s_d.prdata[4:0] = s_q.sense;
        BIPF_OFS_FMT_A, BIPF_OFS_FMT_B: begin
          p = (paddr == BIPF_OFS_FMT_B) ? 1 : 0;
          s_d.prdata[BIPF_FMT_MANT_LSB +: 4] = s_q.mant[p];
          s_d.prdata[BIPF_FMT_EXP_LSB +: 2]  = s_q.expn[p];
          s_d.prdata[BIPF_FMT_FUNC_LSB +: 4] = s_q.func[p];
          s_d.prdata[BIPF_FMT_DP_LSB +: 4]   = s_q.dp[p];
          // Remapping ports under a live transfer would corrupt it
          if (pwrite) begin
            s_d.pslverr = any_busy | ~bipf_fmt_ok(pwdata, (p == 1) ? tot_a : tot_b);
          end
        end
        BIPF_OFS_OUT_LO: s_d.prdata = s_q.out_chars[31:0];
        BIPF_OFS_OUT_HI: begin
          s_d.prdata[11:0]                 = s_q.out_chars[43:32];
          s_d.prdata[BIPF_HI_SIGN_LSB +: 4] = s_q.out_signs;
        end
        BIPF_OFS_IN_ALO: s_d.prdata = s_q.cap[0][31:0];
        BIPF_OFS_IN_AHI: begin
          s_d.prdata[11:0]                 = s_q.cap[0][43:32];
          s_d.prdata[BIPF_HI_SIGN_LSB +: 2] = s_q.cap_sign[0];
        end
        BIPF_OFS_IN_BLO: s_d.prdata = s_q.cap[1][31:0];
        BIPF_OFS_IN_BHI: begin
          s_d.prdata[11:0]                 = s_q.cap[1][43:32];
          s_d.prdata[BIPF_HI_SIGN_LSB +: 2] = s_q.cap_sign[1];
        end
        BIPF_OFS_STATUS: begin
          s_d.prdata[BIPF_ST_BUSY_LSB]     = s_q.st[0] != BIPF_IDLE;
          s_d.prdata[BIPF_ST_BUSY_LSB + 1] = s_q.st[1] != BIPF_IDLE;
          s_d.prdata[BIPF_ST_DONE_LSB +: 2] = s_q.done;
          s_d.prdata[BIPF_ST_FLAG_LSB +: 2] = flag_t;
          s_d.prdata[BIPF_ST_SWITCH]        = s_q.fmt_sw;
        end
        default: s_d.pslverr = 1'b1;
      endcase
      // Read-only words refuse writes
      if (pwrite && (paddr >= BIPF_OFS_IN_ALO) && (paddr <= BIPF_OFS_IN_BHI)) begin
        s_d.pslverr = 1'b1;
      end
    end

    // Register writes take effect in the access phase
    if (wr_acc) begin
      unique case (paddr)
        BIPF_OFS_CTRL: begin
          start    = pwdata[BIPF_CTRL_START_B:BIPF_CTRL_START_A];
          s_d.dir  = pwdata[BIPF_CTRL_DIR_B:BIPF_CTRL_DIR_A];
          load_def = pwdata[BIPF_CTRL_LOADDEF] & ~any_busy;
          def_dual = pwdata[BIPF_CTRL_DUAL];
        end
        BIPF_OFS_SENSE: s_d.sense = pwdata[4:0];
        BIPF_OFS_FMT_A, BIPF_OFS_FMT_B: begin
          p = (paddr == BIPF_OFS_FMT_B) ? 1 : 0;
          s_d.mant[p] = pwdata[BIPF_FMT_MANT_LSB +: 4];
          s_d.expn[p] = pwdata[BIPF_FMT_EXP_LSB +: 2];
          s_d.func[p] = pwdata[BIPF_FMT_FUNC_LSB +: 4];
          s_d.dp[p]   = pwdata[BIPF_FMT_DP_LSB +: 4];
        end
        BIPF_OFS_OUT_LO: s_d.out_chars[31:0] = pwdata;
        BIPF_OFS_OUT_HI: begin
          s_d.out_chars[43:32] = pwdata[11:0];
          s_d.out_signs        = pwdata[BIPF_HI_SIGN_LSB +: 4];
        end
        BIPF_OFS_STATUS: done_clr = pwdata[BIPF_ST_DONE_LSB +: 2];
        default: ;
      endcase
    end

    // Default formats always fit in eleven ports
    if (load_def) begin
      s_d.dp = '0;
      if (def_dual) begin
        s_d.mant = {2{BIPF_DUAL_MANT}};
        s_d.expn = {2{BIPF_DUAL_EXP}};
        s_d.func = {2{BIPF_DUAL_FUNC}};
      end else begin
        s_d.mant = {4'h0, BIPF_STD_MANT};
        s_d.expn = {2'h0, BIPF_STD_EXP};
        s_d.func = {4'h0, BIPF_STD_FUNC};
      end
    end

    // Handshake per channel; a start while busy is dropped
    for (int c = 0; c < 2; c++) begin
      rise = flag_t[c] & ~s_q.flag_prev[c];
      fall = ~flag_t[c] & s_q.flag_prev[c];
      smp  = 1'b0;
      s_d.flag_prev[c] = flag_t[c];
      unique case (s_q.st[c])
        BIPF_IDLE: if (start[c]) s_d.st[c] = BIPF_TRIG;
        BIPF_TRIG: if (rise) begin
          smp = ~s_q.sense[BIPF_SNS_TRAIL];
          s_d.st[c] = BIPF_BUSY;
        end
        BIPF_BUSY: if (fall) begin
          smp = s_q.sense[BIPF_SNS_TRAIL];
          done_set[c] = 1'b1;
          s_d.st[c] = BIPF_IDLE;
        end
        default: s_d.st[c] = BIPF_IDLE;
      endcase
      // Capture packs nibbles from the channel's first port upward
      if (smp && !s_q.dir[c]) begin
        base = (c == 1) ? tot_a : 5'h00;
        ta   = (c == 1) ? tot_b : tot_a;
        mx   = 5'(s_q.mant[c]) + 5'(s_q.expn[c]);
        for (int k = 0; k < BIPF_NPORTS; k++) begin
          p = int'(base) + k;
          s_d.cap[c][BIPF_NIB*k +: BIPF_NIB] = 4'h0;
          if ((5'(k) < ta) && (p < BIPF_NPORTS)) begin
            neg = (5'(k) < mx) ? s_q.sense[BIPF_SNS_DATA] : s_q.sense[BIPF_SNS_FUNC];
            // A floating port reads all ones and decodes by sense
            s_d.cap[c][BIPF_NIB*k +: BIPF_NIB] =
              bipf_code(port_in[BIPF_NIB*p +: BIPF_NIB], neg);
          end
        end
        s_d.cap_sign[c] = sign_port_in[2*c +: 2] ^ {2{s_q.sense[BIPF_SNS_SIGN]}};
      end
    end

    // Done is sticky; a completion in the clearing cycle survives
    s_d.done = (s_q.done & ~done_clr) | done_set;

    // Pin drive follows the next configuration so it changes with it
    ta = bipf_total(s_d.mant[0], s_d.expn[0], s_d.func[0]);
    tb = bipf_total(s_d.mant[1], s_d.expn[1], s_d.func[1]);
    for (int i = 0; i < BIPF_NPORTS; i++) begin
      own_a = 5'(i) < ta;
      own_b = ~own_a & (5'(i) < ta + tb);
      off   = own_a ? 5'(i) : 5'(i) - ta;
      mx    = own_a ? 5'(s_d.mant[0]) + 5'(s_d.expn[0])
                    : 5'(s_d.mant[1]) + 5'(s_d.expn[1]);
      neg   = (off < mx) ? s_d.sense[BIPF_SNS_DATA] : s_d.sense[BIPF_SNS_FUNC];
      s_d.port_out[BIPF_NIB*i +: BIPF_NIB] =
        bipf_code(s_d.out_chars[BIPF_NIB*i +: BIPF_NIB], neg);
      // Unassigned ports are never driven
      s_d.port_oe_n[i] = ~((own_a & s_d.dir[0]) | (own_b & s_d.dir[1]));
    end
    s_d.sign_out  = s_d.out_signs ^ {4{s_d.sense[BIPF_SNS_SIGN]}};
    s_d.sign_oe_n = ~{{2{s_d.dir[1]}}, {2{s_d.dir[0]}}};
    s_d.trig_pin[0] = (s_d.st[0] == BIPF_TRIG) ^ s_d.sense[BIPF_SNS_HS];
    s_d.trig_pin[1] = (s_d.st[1] == BIPF_TRIG) ^ s_d.sense[BIPF_SNS_HS];
    s_d.dir_pin = s_d.dir ^ {2{s_d.sense[BIPF_SNS_HS]}};
  end

  // All state in one register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q <= BIPF_STATE_RST;
    end else begin
      s_q <= s_d;
    end
  end

  // Zero-wait slave: the access phase always completes
  assign pready         = penable;
  assign prdata         = s_q.prdata;
  assign pslverr        = s_q.pslverr & psel & penable;
  assign port_out       = s_q.port_out;
  assign port_oe_n      = s_q.port_oe_n;
  assign sign_port_out  = s_q.sign_out;
  assign sign_port_oe_n = s_q.sign_oe_n;
  assign trigger_a      = s_q.trig_pin[0];
  assign trigger_b      = s_q.trig_pin[1];
  assign direction_a    = s_q.dir_pin[0];
  assign direction_b    = s_q.dir_pin[1];

endmodule

// >>> verification/bipf_formatter_sva.sv
`timescale 1ns/1ns
module bipf_formatter_sva
  import bipf_pkg::*;
(
  // Bus side
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // Pin side
  input wire logic [10:0] port_oe_n,
  input wire logic [3:0]  sign_port_oe_n,
  input wire logic        direction_a,
  input wire logic        direction_b,
  input wire logic        trigger_a,
  input wire logic        ready_flag_a
);
  logic hs_q;
  logic acc, wr, da, db, tr, fl;
  // Pins are judged at their true level, so follow the handshake sense
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) hs_q <= 1'b0;
    else if (wr && paddr == BIPF_OFS_SENSE && !pslverr) hs_q <= pwdata[BIPF_SNS_HS];
  end
  assign acc = psel && penable;
  assign wr  = acc && pwrite;
  assign da  = direction_a ^ hs_q;
  assign db  = direction_b ^ hs_q;
  assign tr  = trigger_a ^ hs_q;
  assign fl  = ready_flag_a ^ hs_q;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Start on an idle channel; a sense change may lag the pins a cycle
  sequence s_start_a;
    wr && paddr == BIPF_OFS_CTRL && pwdata[0] && !tr && !fl && !$past(fl);
  endsequence
  sequence s_flag_rise_a;
    tr && $stable(hs_q) && $rose(fl);
  endsequence
  a_pready_access: assert property (acc |-> pready) else $error("no ready in access");
  a_err_phase: assert property (pslverr |-> acc) else $error("error outside access");
  a_bad_addr: assert property (acc && (paddr > BIPF_OFS_STATUS || paddr[1:0] != 2'b00)
    |-> pslverr) else $error("bad address taken");
  a_fmt_range: assert property (wr && paddr == BIPF_OFS_FMT_A
    && (pwdata[3:0] > BIPF_MAX_MANT || pwdata[11:8] > BIPF_MAX_FUNC) |-> pslverr)
    else $error("digit count taken");
  a_fmt_total: assert property (wr && paddr == BIPF_OFS_FMT_A
    && (6'(pwdata[3:0]) + 6'(pwdata[5:4]) + 6'(pwdata[11:8])) > BIPF_MAX_TOTAL |-> pslverr)
    else $error("total taken");
  a_dir_out: assert property (wr && paddr == BIPF_OFS_CTRL && pwdata[BIPF_CTRL_DIR_A]
    |-> ##[1:2] da) else $error("direction not output");
  a_oe_dir: assert property ((port_oe_n != 11'h7FF || sign_port_oe_n != 4'hF)
    |-> da || db || $past(da) || $past(db)) else $error("drive while input");
  a_trig_start: assert property (s_start_a |-> ##[1:3] tr)
    else $error("trigger not raised");
  a_trig_hold: assert property (tr && $stable(hs_q) && !fl && !$past(fl) |=> tr)
    else $error("trigger dropped early");
  a_trig_drop: assert property (s_flag_rise_a |-> ##[1:3] !tr)
    else $error("trigger kept after flag");
endmodule

bind bipf_formatter bipf_formatter_sva u_sva (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
  .pslverr(pslverr), .port_oe_n(port_oe_n), .sign_port_oe_n(sign_port_oe_n),
  .direction_a(direction_a), .direction_b(direction_b), .trigger_a(trigger_a),
  .ready_flag_a(ready_flag_a));

// >>> verification/bipf_instrument.sv
`timescale 1ns/1ns
module bipf_instrument (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // Handshake
  input  wire logic        trigger,
  input  wire logic        hs_neg,
  input  wire logic [3:0]  delay,
  output logic             flag,
  // Reading: digits in [43:0], signs in [47:44]
  input  wire logic [47:0] reading,
  output logic      [47:0] data
);
  logic [1:0] ph_q;
  logic [3:0] cnt_q;
  logic       busy_q, valid_q;
  // Wait, measure with flag true, then hold data briefly past the flag fall
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) {ph_q, cnt_q, busy_q, valid_q} <= '0;
    else if (cnt_q != 4'h0) cnt_q <= cnt_q - 4'h1;
    else case (ph_q)
      2'h0: if (trigger ^ hs_neg) {ph_q, cnt_q} <= {2'h1, delay};
      2'h1: {ph_q, cnt_q, busy_q, valid_q} <= {2'h2, 4'h3, 2'b11};
      2'h2: {ph_q, cnt_q, busy_q} <= {2'h3, 4'h2, 1'b0};
      default: {ph_q, valid_q} <= 3'b000;
    endcase
  end
  // Idle lines show the inverse, so a stale copy never passes
  assign data = valid_q ? reading : ~reading;
  assign flag = busy_q ^ hs_neg;
endmodule

// >>> verification/bipf_formatter_test.sv
`timescale 1ns/1ns
module bipf_formatter_test
  import bipf_pkg::*;
;
  localparam logic [47:0] RD_A = 48'h1A9876543210;
  localparam logic [7:0]  TA [7] = '{8'h0C, 8'h08, 8'h08, 8'h2C, 8'h18, 8'h08, 8'h08};
  localparam logic [31:0] TD [7] = '{32'h1, 32'hC, 32'hC00, 32'h0, 32'h0, 32'h2038, 32'h8038};
  localparam logic        TE [7] = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b1};
  logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata;
  logic        pready, pslverr, sw = 1'b0, dir_a, dir_b, trg_a, trg_b, fl_a, fl_b;
  logic [43:0] p_in, p_out;
  logic [10:0] p_oe_n, m_a = 11'h3FF, m_b = 11'h000;
  logic [3:0]  s_in, s_out, s_oe_n, dly = 4'h9;
  logic [47:0] rd_a = RD_A, rd_b = 48'h4A9876543210, d_a, d_b;
  logic        en = 1'b1, hs = 1'b0;
  int          num_errors = 0, checks = 0;

  always #25 pclk = ~pclk;

  bipf_formatter uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .format_select_switch(sw), .port_in(p_in), .port_out(p_out),
    .port_oe_n(p_oe_n), .sign_port_in(s_in), .sign_port_out(s_out), .sign_port_oe_n(s_oe_n),
    .direction_a(dir_a), .direction_b(dir_b), .trigger_a(trg_a), .trigger_b(trg_b),
    .ready_flag_a(fl_a), .ready_flag_b(fl_b));
  bipf_instrument inst_a (.clk(pclk), .rst_n(presetn & en), .trigger(trg_a), .hs_neg(hs),
    .delay(dly), .flag(fl_a), .reading(rd_a), .data(d_a));
  bipf_instrument inst_b (.clk(pclk), .rst_n(presetn & en), .trigger(trg_b), .hs_neg(hs),
    .delay(dly), .flag(fl_b), .reading(rd_b), .data(d_b));

  // Device drive wins, then an instrument; a free line floats high
  always_comb begin
    for (int i = 0; i < 11; i++)
      p_in[4*i +: 4] = !p_oe_n[i] ? p_out[4*i +: 4] : m_a[i] ? d_a[4*i +: 4] :
                       m_b[i] ? d_b[4*i +: 4] : 4'hF;
    for (int j = 0; j < 4; j++)
      s_in[j] = !s_oe_n[j] ? s_out[j] : (j < 2) ? d_a[44+j] : d_b[44+j];
  end

  task automatic chk(input string nm, input logic [47:0] exp, input logic [47:0] got);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // One transfer; the request stands until pready is sampled high
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // No assumed wait count: only the watchdog ends a stuck access
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic ee);
    logic [31:0] r;
    logic        e;
    apb(a, 1'b1, d, r, e);
    chk($sformatf("err %h", a), {47'h0, ee}, {47'h0, e});
  endtask

  task automatic rd(input logic [7:0] a, input logic [47:0] exp);
    logic [31:0] r;
    logic        e;
    apb(a, 1'b0, 32'h0, r, e);
    chk($sformatf("reg %h", a), exp, {16'h0, r});
  endtask

  // Start an input transfer, poll for done, check fields, clear done
  task automatic xfer(input int ch, input logic [31:0] lo, input logic [31:0] hi);
    logic [31:0] r;
    logic        e;
    int          n = 0;
    wr(BIPF_OFS_CTRL, 32'h1 << ch, 1'b0);
    do apb(BIPF_OFS_STATUS, 1'b0, 32'h0, r, e); while (r[2+ch] !== 1'b1 && n++ < 40);
    chk("done", 48'h1, {47'h0, r[2+ch]});
    rd(ch ? BIPF_OFS_IN_BLO : BIPF_OFS_IN_ALO, {16'h0, lo});
    rd(ch ? BIPF_OFS_IN_BHI : BIPF_OFS_IN_AHI, {16'h0, hi});
    wr(BIPF_OFS_STATUS, 32'h4 << ch, 1'b0);
  endtask

  task automatic do_reset(input logic s);
    sw <= s;
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
  endtask

  task automatic end_of_test;
    $display("checks %0d mismatches %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  // Watchdog: the whole run needs a few hundred cycles
  initial begin
    repeat (20000) @(posedge pclk);
    num_errors++;
    end_of_test();
  end

  initial begin
    do_reset(1'b0);
    rd(BIPF_OFS_FMT_A, 48'h118);
    rd(BIPF_OFS_FMT_B, 48'h0);
    rd(BIPF_OFS_SENSE, 48'h0);
    chk("oe", 48'h7FFF, {33'h0, s_oe_n, p_oe_n});
    $display("test defaults done");
    xfer(0, 32'h76543210, 32'h00010098);
    $display("test leading input done");
    // Instruments held idle while the sense flips, to avoid a false trigger
    en <= 1'b0;
    wr(BIPF_OFS_SENSE, 32'h1F, 1'b0);
    chk("idle pins", 48'hF, {44'h0, dir_b, dir_a, trg_b, trg_a});
    hs <= 1'b1;
    rd_a <= ~RD_A;
    dly <= 4'h0;
    en <= 1'b1;
    xfer(0, 32'h76543210, 32'h00010098);
    $display("test negative trailing done");
    en <= 1'b0;
    wr(BIPF_OFS_SENSE, 32'h0, 1'b0);
    hs <= 1'b0;
    rd_a <= 48'h0A9876543210;
    dly <= 4'h3;
    en <= 1'b1;
    wr(BIPF_OFS_FMT_A, 32'h00B, 1'b0);
    xfer(0, 32'h76543210, 32'h00000F98);
    for (int k = 0; k < 7; k++) wr(TA[k], TD[k], TE[k]);
    rd(BIPF_OFS_FMT_A, 48'h2038);
    rd(BIPF_OFS_FMT_B, 48'h0);
    $display("test formats done");
    wr(BIPF_OFS_SENSE, 32'h2, 1'b0);
    wr(BIPF_OFS_OUT_LO, 32'h76543210, 1'b0);
    wr(BIPF_OFS_OUT_HI, 32'h00030A98, 1'b0);
    wr(BIPF_OFS_CTRL, 32'h4, 1'b0);
    repeat (2) @(posedge pclk);
    chk("drive", {4'h3, ~44'hA9876543210}, {s_out, p_out});
    chk("pins", 48'hE000, {32'h0, dir_a, s_oe_n, p_oe_n});
    // Function sense alone must leave mantissa and exponent ports plain
    wr(BIPF_OFS_SENSE, 32'h4, 1'b0);
    chk("func sense", {4'h3, 44'hA9876543210}, {s_out, p_out});
    wr(BIPF_OFS_CTRL, 32'h0, 1'b0);
    repeat (2) @(posedge pclk);
    chk("release", 48'h7FFF, {33'h0, s_oe_n, p_oe_n});
    $display("test output done");
    do_reset(1'b1);
    rd(BIPF_OFS_FMT_A, 48'h104);
    rd(BIPF_OFS_FMT_B, 48'h104);
    rd(BIPF_OFS_STATUS, 48'h40);
    m_a <= 11'h01F;
    m_b <= 11'h3E0;
    xfer(1, 32'h00098765, 32'h00010000);
    $display("test dual done");
    end_of_test();
  end
endmodule
